//--- inc/wdnr_cd_if.sv
/*
  Interface between the register block and the countdown sequencer.
  Assumes both ends share aclk and aresetn.
*/
`timescale 1ns/10ps
`default_nettype none

interface wdnr_cd_if;
  import wdnr_pkg::*;

  logic       start;     // Pulse: non-maskable request accepted
  wdnr_cnt_t  load_val;  // Programmed countdown start value
  logic       step;      // Instruction-cycle tick
  logic       running;   // Countdown in progress
  logic       fire;      // Pulse: countdown expired
  wdnr_cnt_t  remain;    // Current countdown value

  modport ctrl (output start, output load_val, output step,
                input running, input fire, input remain);
  modport cdn  (input start, input load_val, input step,
                output running, output fire, output remain);
endinterface

`default_nettype wire

//--- inc/wdnr_pkg.sv
/*
  Types shared by the watchdog interrupt-then-reset block.
  Assumes the constants header is available on the include path.
*/
package wdnr_pkg;

  // Countdown sequencer states
  typedef enum logic [1:0] {
    WDNR_IDLE  = 2'b00,
    WDNR_COUNT = 2'b01,
    WDNR_RESET = 2'b10
  } wdnr_state_e;

  typedef logic [15:0] wdnr_cnt_t;

endpackage

//--- inc/wdnr_regs.svh
/*
  Register offsets, field positions, reset values and bus response codes for
  the watchdog interrupt-then-reset block.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
`ifndef WDNR_REGS_SVH
`define WDNR_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define WDNR_OFS_IRC       12'h000
`define WDNR_OFS_PWR       12'h004
`define WDNR_OFS_WDC       12'h008
`define WDNR_OFS_SRC       12'h00C

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define WDNR_IRC_TO_BIT    24
`define WDNR_IRC_DMT_BIT   25
`define WDNR_IRC_FAILSAFE_CLOCK_MONITOR_BIT  26
`define WDNR_IRC_CNT_LSB   0
`define WDNR_IRC_CNT_MSB   15
`define WDNR_PWR_VREG_BIT  0
`define WDNR_WDC_WIN_BIT   0
`define WDNR_WDC_PS_LSB    8
`define WDNR_WDC_PS_MSB    12
`define WDNR_SRC_RUN_BIT   0
`define WDNR_SRC_RST_BIT   1

// ----------------------------------------------------------------------
// Reset values, widths and bus response codes
// ----------------------------------------------------------------------
`define WDNR_CNT_W         16
`define WDNR_CNT_RST       16'hFFFF
`define WDNR_PS_RST        5'h00
`define WDNR_RESP_OKAY     2'b00
`define WDNR_RESP_SLVERR   2'b10

`endif

//--- src/wdnr_countdown.sv
/*
  Countdown sequencer: loads the programmed value on a non-maskable request,
  steps down once per instruction tick and fires on reaching zero.
  Assumes start is a one-cycle pulse from the register block.
*/
`timescale 1ns/10ps
`default_nettype none

module wdnr_countdown (
  // Clock and reset
  input  wire logic  aclk,
  input  wire logic  aresetn,
  // Link to register block
  wdnr_cd_if.cdn     cd
);
  import wdnr_pkg::*;

  wdnr_state_e state_q;
  wdnr_state_e state_d;
  wdnr_cnt_t   cnt_q;
  wdnr_cnt_t   cnt_d;

  // Next state and count
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      WDNR_IDLE: begin
        if (cd.start) begin
          state_d = WDNR_COUNT;
          cnt_d   = cd.load_val;
        end
      end
      WDNR_COUNT: begin
        if (cnt_q == '0) begin
          state_d = WDNR_RESET;
        end else if (cd.step) begin
          cnt_d = cnt_q - 16'h0001;
        end
      end
      WDNR_RESET: begin
        state_d = WDNR_IDLE;
      end
      default: begin
        state_d = WDNR_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= WDNR_IDLE;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  assign cd.running = (state_q == WDNR_COUNT);
  assign cd.fire    = (state_q == WDNR_RESET);
  assign cd.remain  = cnt_q;

endmodule

`default_nettype wire

//--- src/wdnr_top.sv
/*
  Watchdog interrupt-then-reset controller with AXI4-Lite registers.
  Assumes synchronous single-cycle event pulses from the timers and an
  instruction tick input; the device reset output is a one-cycle pulse.
*/
`timescale 1ns/10ps
`default_nettype none
`include "wdnr_regs.svh"

module wdnr_top #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Timer event pulses and instruction tick
  input  wire logic                watchdog_expiry_indicator,
  input  wire logic                deadman_timer_event,
  input  wire logic                failsafe_clock_monitor_event,
  input  wire logic                instr_tick,
  // Outputs to the rest of the device
  output logic                     nmi_req,
  output logic                     device_reset,
  output logic                     sleep_regulator_keep,
  output logic                     window_mode_enable,
  output logic [4:0]               watchdog_postscale
);
  import wdnr_pkg::*;

  // Refuse address widths that the 12-bit offset decode cannot serve
  if (ADDR_W < 4 || ADDR_W > 12) begin : g_addr_w_bad
    $error("ADDR_W must lie between 4 and 12");
  end

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic       wdt_to_q;
  logic       dmt_ev_q;
  logic       failsafe_clock_monitor_ev_q;
  wdnr_cnt_t  cnt_q;
  logic       vreg_q;
  logic       win_q;
  logic [4:0] ps_q;
  logic       nmi_q;
  logic       rst_q;

  logic              aw_q;
  logic              w_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;

  wdnr_cd_if cd_if ();

  // ----------------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------------
  wire any_req  = watchdog_expiry_indicator | deadman_timer_event |
                  failsafe_clock_monitor_event;
  wire req_take = any_req & ~cd_if.running & ~cd_if.fire; // Idle only

  // Write channel decode
  wire        wr_go   = aw_q & w_q & ~bvalid_q;
  wire [11:0] wr_ofs  = 12'({awaddr_q[ADDR_W-1:2], 2'b00});
  wire        wr_irc  = wr_go & (wr_ofs == `WDNR_OFS_IRC);
  wire        wr_pwr  = wr_go & (wr_ofs == `WDNR_OFS_PWR);
  wire        wr_wdc  = wr_go & (wr_ofs == `WDNR_OFS_WDC);
  wire        wr_src  = wr_go & (wr_ofs == `WDNR_OFS_SRC);
  wire        wr_hit  = wr_irc | wr_pwr | wr_wdc | wr_src;

  // Write-one-to-clear of sticky flags, event wins over clear
  wire clr_to   = wr_irc & wstrb_q[3] & wdata_q[`WDNR_IRC_TO_BIT];
  wire clr_dmt  = wr_irc & wstrb_q[3] & wdata_q[`WDNR_IRC_DMT_BIT];
  wire clr_failsafe_clock_monitor = wr_irc & wstrb_q[3] & wdata_q[`WDNR_IRC_FAILSAFE_CLOCK_MONITOR_BIT];

  // Read decode
  wire        rd_go  = s_axi_arvalid & ~rvalid_q;
  wire [11:0] rd_ofs = 12'({s_axi_araddr[ADDR_W-1:2], 2'b00});
  wire [31:0] irc_rd = {5'h00, failsafe_clock_monitor_ev_q, dmt_ev_q, wdt_to_q, 8'h00, cnt_q};
  wire [31:0] pwr_rd = {31'h0000_0000, vreg_q};
  wire [31:0] wdc_rd = {19'h0_0000, ps_q, 7'h00, win_q};
  wire [31:0] src_rd = {16'h0000, cd_if.remain[15:2], rst_q, cd_if.running};
  wire        rd_irc = (rd_ofs == `WDNR_OFS_IRC);
  wire        rd_pwr = (rd_ofs == `WDNR_OFS_PWR);
  wire        rd_wdc = (rd_ofs == `WDNR_OFS_WDC);
  wire        rd_src = (rd_ofs == `WDNR_OFS_SRC);
  wire        rd_hit = rd_irc | rd_pwr | rd_wdc | rd_src;
  wire [31:0] rd_mux = rd_irc ? irc_rd :
                       rd_pwr ? pwr_rd :
                       rd_wdc ? wdc_rd :
                       rd_src ? src_rd : 32'h0000_0000;

  // Countdown link
  assign cd_if.start    = req_take;
  assign cd_if.load_val = cnt_q;
  assign cd_if.step     = instr_tick;

  wdnr_countdown u_cd (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cd      (cd_if.cdn)
  );

  // ----------------------------------------------------------------------
  // AXI4-Lite handshake registers
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= '0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= `WDNR_RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `WDNR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_q) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_q) begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_q     <= 1'b0;
        w_q      <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= wr_hit ? `WDNR_RESP_OKAY : `WDNR_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (rd_go) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_mux;
        rresp_q  <= rd_hit ? `WDNR_RESP_OKAY : `WDNR_RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Control and status registers
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdt_to_q  <= 1'b0;
      dmt_ev_q  <= 1'b0;
      failsafe_clock_monitor_ev_q <= 1'b0;
      cnt_q     <= `WDNR_CNT_RST;
      vreg_q    <= 1'b0;
      win_q     <= 1'b0;
      ps_q      <= `WDNR_PS_RST;
    end else begin
      wdt_to_q  <= watchdog_expiry_indicator | (wdt_to_q & ~clr_to);
      dmt_ev_q  <= deadman_timer_event | (dmt_ev_q & ~clr_dmt);
      failsafe_clock_monitor_ev_q <= failsafe_clock_monitor_event |
                   (failsafe_clock_monitor_ev_q & ~clr_failsafe_clock_monitor);
      if (wr_irc && wstrb_q[0]) cnt_q[7:0] <= wdata_q[7:0];
      if (wr_irc && wstrb_q[1]) cnt_q[15:8] <= wdata_q[15:8];
      if (wr_pwr && wstrb_q[0]) vreg_q <= wdata_q[`WDNR_PWR_VREG_BIT];
      if (wr_wdc && wstrb_q[0]) win_q <= wdata_q[`WDNR_WDC_WIN_BIT];
      if (wr_wdc && wstrb_q[1]) begin
        ps_q <= wdata_q[`WDNR_WDC_PS_MSB:`WDNR_WDC_PS_LSB];
      end
    end
  end

  // Interrupt and reset outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nmi_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      nmi_q <= req_take;
      rst_q <= cd_if.fire;
    end
  end

  assign s_axi_awready        = ~aw_q;
  assign s_axi_wready         = ~w_q;
  assign s_axi_bvalid         = bvalid_q;
  assign s_axi_bresp          = bresp_q;
  assign s_axi_arready        = ~rvalid_q;
  assign s_axi_rvalid         = rvalid_q;
  assign s_axi_rdata          = rdata_q;
  assign s_axi_rresp          = rresp_q;
  assign nmi_req              = nmi_q;
  assign device_reset         = rst_q;
  assign sleep_regulator_keep = vreg_q;
  assign window_mode_enable   = win_q;
  assign watchdog_postscale   = ps_q;

endmodule

`default_nettype wire

//--- verification/tb_wdnr_top.sv
/*
  Self-checking bench for the watchdog interrupt-then-reset controller.
  Assumes the checker binds itself to the design.
*/
`timescale 1ns/10ps
`default_nettype none
`include "wdnr_regs.svh"

module tb_wdnr_top;
  localparam logic [1:0] OK  = `WDNR_RESP_OKAY;
  localparam logic [1:0] ERR = `WDNR_RESP_SLVERR;
  // ----
  // Bench signals
  // ----
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = '0;
  logic [2:0]  ev = '0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, instr_tick = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, nmi_req, device_reset, sleep_regulator_keep;
  logic        window_mode_enable;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [4:0]  watchdog_postscale;
  logic [33:0] x_q[$], e_q[$];
  int          err_count = 0, samples_checked = 0, n;

  // 50 MHz clock
  always #10 aclk = ~aclk;

  wdnr_top dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .watchdog_expiry_indicator(ev[0]),
    .deadman_timer_event(ev[1]), .failsafe_clock_monitor_event(ev[2]),
    .instr_tick, .nmi_req, .device_reset, .sleep_regulator_keep,
    .window_mode_enable, .watchdog_postscale
  );

  // ----
  // Checking helpers
  // ----
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  function automatic logic [33:0] pop(ref logic [33:0] q[$]);
    return (q.size() != 0) ? q.pop_front() : 'x;
  endfunction

  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic hang();
    err_count++;
    close_out();
  endtask

  // One bus transfer; the expected answer goes to the queue first
  task automatic bus(input bit w, input logic [11:0] a,
                     input logic [31:0] v, input logic [3:0] s,
                     input logic [1:0] r);
    int i;
    x_q.push_back(w ? 34'(r) : {r, v});
    s_axi_awaddr  <= a;
    s_axi_araddr  <= a;
    s_axi_wdata   <= v;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= w;
    s_axi_wvalid  <= w;
    s_axi_bready  <= w;
    s_axi_arvalid <= !w;
    s_axi_rready  <= !w;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_bvalid || s_axi_rvalid) break;
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
    if (i == 40) hang();
  endtask

  // Give c instruction ticks, with random idle cycles between
  task automatic tk(input int c);
    logic b;
    while (c > 0) begin
      b = ($urandom_range(0, 2) != 0);
      instr_tick <= b;
      c -= int'(b);
      @(posedge aclk);
    end
    instr_tick <= 1'b0;
  endtask

  task automatic pulse(input int k);
    ev[k] <= 1'b1;
    @(posedge aclk);
    ev[k] <= 1'b0;
    @(posedge aclk);
  endtask

  // Wait until every noted pulse has been seen
  task automatic drain();
    repeat (20) if (e_q.size() != 0) @(posedge aclk);
    if (e_q.size() != 0) hang();
  endtask

  // Match each answer and output pulse with the oldest note
  always @(posedge aclk) begin
    if ((s_axi_bvalid & s_axi_bready) !== 1'b0)
      chk(34'(s_axi_bresp), pop(x_q));
    if ((s_axi_rvalid & s_axi_rready) !== 1'b0)
      chk({s_axi_rresp, s_axi_rdata}, pop(x_q));
    if ((nmi_req | device_reset) !== 1'b0)
      chk(34'({device_reset, nmi_req}), pop(e_q));
  end

  // ----
  // Scenarios
  // ----
  initial begin
    void'($urandom(32'he29f_e4b9));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    bus(0, 12'h000, 32'h0000_FFFF, 4'h0, OK);
    bus(0, 12'h004, 32'h0, 4'h0, OK);
    bus(0, 12'h008, 32'h0, 4'h0, OK);
    bus(0, 12'h010, 32'h0, 4'h0, ERR);
    bus(1, 12'h020, 32'hFFFF_FFFF, 4'hF, ERR);
    for (n = 0; n < 2; n++) begin
      d = n ? ~d : $urandom();
      bus(1, 12'h004, d, 4'hF, OK);
      chk(34'(sleep_regulator_keep), 34'(d[0]));
      bus(0, 12'h004, {31'h0, d[0]}, 4'h0, OK);
      bus(1, 12'h008, d, 4'hF, OK);
      chk(34'({watchdog_postscale, window_mode_enable}),
          34'({d[12:8], d[0]}));
      bus(0, 12'h008, d & 32'h0000_1F01, 4'h0, OK);
    end
    for (int k = 0; k < 3; k++) begin
      n = (k == 1) ? 0 : $urandom_range(3, 12);
      bus(1, 12'h000, n, 4'b0011, OK);
      e_q.push_back(34'h1);
      if (n == 0) e_q.push_back(34'h2);
      pulse(k);
      drain();
      if (n != 0) begin
        pulse(k);
        tk(1);
        bus(0, 12'h00C, ((n - 1) & 32'h0000_FFFC) | 32'h1, 4'h0, OK);
        tk(n - 2);
        repeat (4) @(posedge aclk);
        e_q.push_back(34'h2);
        tk(1);
        drain();
      end
      bus(0, 12'h000, (32'h1 << (24 + k)) | n, 4'h0, OK);
      bus(1, 12'h000, 32'h0700_0000, 4'b1000, OK);
      bus(0, 12'h000, n, 4'h0, OK);
    end
    close_out();
  end
endmodule

`default_nettype wire

//--- verification/wdnr_top_checker.sv
/*
  Port assertions for the watchdog interrupt-then-reset controller.
  Assumes address and data of a write are offered together.
*/
`timescale 1ns/10ps
`default_nettype none

module wdnr_top_chk #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // Register writes
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic [3:0]        s_axi_wstrb,
  input wire logic              s_axi_wvalid,
  // Events and tick
  input wire logic              watchdog_expiry_indicator,
  input wire logic              deadman_timer_event,
  input wire logic              failsafe_clock_monitor_event,
  input wire logic              instr_tick,
  // Device outputs
  input wire logic              nmi_req,
  input wire logic              device_reset,
  input wire logic              sleep_regulator_keep,
  input wire logic              window_mode_enable,
  input wire logic [4:0]        watchdog_postscale
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ----
  // Helper state
  // ----
  logic             run_q;
  logic [16:0]      ticks_q;
  logic [15:0]      cnt_q;
  wire              any_ev = watchdog_expiry_indicator | deadman_timer_event
                             | failsafe_clock_monitor_event;
  wire              wr_go  = s_axi_awvalid & s_axi_awready & s_axi_wvalid;
  wire [ADDR_W-3:0] wr_idx = s_axi_awaddr[ADDR_W-1:2];

  // Countdown activity, ticks since the interrupt, programmed start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_q   <= 1'b0;
      ticks_q <= '0;
      cnt_q   <= 16'hFFFF;
    end else begin
      run_q   <= nmi_req | (run_q & ~device_reset);
      ticks_q <= nmi_req ? '0 : ticks_q + {16'h0, instr_tick};
      if (wr_go && wr_idx == '0 && s_axi_wstrb[1:0] == 2'b11) begin
        cnt_q <= s_axi_wdata[15:0];
      end
    end
  end

  // ----
  // Properties
  // ----
  nmi_cause_a: assert property (
    nmi_req |-> $past(any_ev) && !run_q)
    else $error("interrupt without an event while idle");
  nmi_idle_a: assert property (
    any_ev && !run_q && !nmi_req && !device_reset && !$past(device_reset)
    |=> nmi_req)
    else $error("idle event raised no interrupt");
  rst_gap_a: assert property (nmi_req |=> !device_reset)
    else $error("reset came at once with the interrupt");
  rst_pulse_a: assert property (device_reset |=> !device_reset)
    else $error("reset pulse too long");
  rst_count_a: assert property (
    device_reset |-> run_q && ticks_q + 17'd1 >= {1'b0, cnt_q}
    && ticks_q <= {1'b0, cnt_q} + 17'd4)
    else $error("reset not after the programmed ticks");
  pwr_bit_a: assert property (
    wr_go && wr_idx == 1 && s_axi_wstrb[0]
    |-> ##2 sleep_regulator_keep == $past(s_axi_wdata[0], 2))
    else $error("regulator bit did not follow the write");
  win_bit_a: assert property (
    wr_go && wr_idx == 2 && s_axi_wstrb[0]
    |-> ##2 window_mode_enable == $past(s_axi_wdata[0], 2))
    else $error("window enable did not follow the write");
  ps_field_a: assert property (
    wr_go && wr_idx == 2 && s_axi_wstrb[1]
    |-> ##2 watchdog_postscale == $past(s_axi_wdata[12:8], 2))
    else $error("postscale did not follow the write");
endmodule

bind wdnr_top wdnr_top_chk #(.ADDR_W(ADDR_W)) u_chk (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .watchdog_expiry_indicator,
  .deadman_timer_event, .failsafe_clock_monitor_event, .instr_tick,
  .nmi_req, .device_reset, .sleep_regulator_keep, .window_mode_enable,
  .watchdog_postscale
);

`default_nettype wire
